// *** rtl/spm_defines.svh ***
// offsets, field positions, reset values and counts of the serial port
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
`define SPM_OFS_CTRL   4'h0
`define SPM_OFS_STAT   4'h4
`define SPM_OFS_DATA   4'h8
`define SPM_CTRL_IRQEN 7
`define SPM_CTRL_PEN   6
`define SPM_CTRL_ROLE  4
`define SPM_CTRL_CLOCK_POLARITY_BIT  3
`define SPM_CTRL_CLOCK_PHASE_BIT  2
`define SPM_STAT_TC    7
`define SPM_STAT_WRITE_COLLISION_FLAG  6
`define SPM_STAT_MODE_FAULT_FLAG  4
`define SPM_CTRL_RST   8'h00
`define SPM_DATA_RST   8'h00
`define SPM_DIV0       2
`define SPM_DIV1       4
`define SPM_DIV2       16
`define SPM_DIV3       32
`define SPM_LAST_EDGE  4'hF
`endif

// *** rtl/spm_pkg.sv ***
// types shared by the serial port
package spm_pkg;
   typedef logic [7:0]  spm_byte_t;
   typedef logic [31:0] spm_word_t;
   typedef enum logic {SPM_IDLE, SPM_RUN} spm_mstate_t;
endpackage

// *** rtl/spm_port.sv ***
// byte-wide serial port, master or slave, behind a classic wishbone slave
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "spm_defines.svh"

module spm_port #(
   parameter int ADDR_W = 4,
   parameter int DIV0   = `SPM_DIV0,
   parameter int DIV1   = `SPM_DIV1,
   parameter int DIV2   = `SPM_DIV2,
   parameter int DIV3   = `SPM_DIV3
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire spm_pkg::spm_word_t wb_dat_i,
   output      spm_pkg::spm_word_t wb_dat_o,
   output      logic              wb_ack_o,
   output      logic              irq_o,
   input  wire logic              sck_i,
   output      logic              sck_o,
   output      logic              sck_oe,
   input  wire logic              mosi_i,
   output      logic              mosi_o,
   output      logic              mosi_oe,
   input  wire logic              miso_i,
   output      logic              miso_o,
   output      logic              miso_oe,
   input  wire logic              ss_n_i
);
   import spm_pkg::*;

   initial begin
      if (ADDR_W < 4 || DIV0 < 2 || DIV1 < 2 || DIV2 < 2 || DIV3 < 2 ||
          DIV0 % 2 != 0 || DIV1 % 2 != 0 || DIV2 % 2 != 0 || DIV3 % 2 != 0 ||
          DIV3 > 512)
         $error("spm_port: unsupported parameter");
   end

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   logic [1:0] sck_s, mosi_s, miso_s, ss_s;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sck_s  <= 2'h0;
         mosi_s <= 2'h0;
         miso_s <= 2'h0;
         ss_s   <= 2'h3;
      end else begin
         sck_s  <= {sck_s[0], sck_i};
         mosi_s <= {mosi_s[0], mosi_i};
         miso_s <= {miso_s[0], miso_i};
         ss_s   <= {ss_s[0], ss_n_i};
      end
   end

   logic sck_old_q;
   logic ss_low;
   assign ss_low = !ss_s[1];

   // -----------------------------------------------------------------
   // registers and bus
   // -----------------------------------------------------------------
   spm_byte_t   ctrl_q, sh_q, rx_q, sh_nxt;
   logic        tc_q, write_collision_flag_q, mode_fault_flag_q, seen_q, ack_q;
   spm_mstate_t m_state;
   logic [3:0]  eidx_q;
   logic        sl_run_q;
   logic        pen, role, clock_polarity_bit, clock_phase_bit;
   logic        req, rd_stat, rd_data, wr_data, wr_ctrl, dacc;
   logic        busy, blocked, edge_ev, edge_in, done_ev;

   assign pen  = ctrl_q[`SPM_CTRL_PEN];
   assign role = ctrl_q[`SPM_CTRL_ROLE];
   assign clock_polarity_bit = ctrl_q[`SPM_CTRL_CLOCK_POLARITY_BIT];
   assign clock_phase_bit = ctrl_q[`SPM_CTRL_CLOCK_PHASE_BIT];

   assign req     = wb_cyc_i && wb_stb_i && !ack_q;
   assign rd_stat = req && !wb_we_i && wb_adr_i[3:0] == `SPM_OFS_STAT;
   assign rd_data = req && !wb_we_i && wb_adr_i[3:0] == `SPM_OFS_DATA;
   assign wr_data = req && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i[3:0] == `SPM_OFS_DATA;
   assign wr_ctrl = req && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i[3:0] == `SPM_OFS_CTRL;
   assign dacc    = rd_data || wr_data;

   // one wait state: ack in the cycle after the request is seen
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_q    <= req;
         wb_dat_o <= 32'h0;
         if (req && !wb_we_i) begin
            case (wb_adr_i[3:0])
               `SPM_OFS_CTRL: wb_dat_o <= {24'h0, ctrl_q};
               `SPM_OFS_STAT: wb_dat_o <= {24'h0, tc_q, write_collision_flag_q, 1'b0,
                                           mode_fault_flag_q, 4'h0};
               `SPM_OFS_DATA: wb_dat_o <= {24'h0, rx_q};
               default:       wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         ctrl_q <= `SPM_CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= wb_dat_i[7:0];
   end

   // -----------------------------------------------------------------
   // master clock generator
   // -----------------------------------------------------------------
   logic [8:0] div_q, half;
   logic       tick, sck_q;

   always_comb begin
      case (ctrl_q[1:0])
         2'h0:    half = 9'(DIV0 / 2);
         2'h1:    half = 9'(DIV1 / 2);
         2'h2:    half = 9'(DIV2 / 2);
         default: half = 9'(DIV3 / 2);
      endcase
   end
   assign tick = m_state == SPM_RUN && div_q == half - 9'h1;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         div_q <= 9'h0;
      else if (m_state != SPM_RUN || tick)
         div_q <= 9'h0;
      else
         div_q <= div_q + 9'h1;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         sck_q <= 1'b0;
      else if (m_state != SPM_RUN)
         sck_q <= clock_polarity_bit;
      else if (tick)
         sck_q <= !sck_q;
   end

   // -----------------------------------------------------------------
   // edge source: generated clock as master, pin clock as slave
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         sck_old_q <= 1'b0;
      else
         sck_old_q <= sck_s[1];
   end

   always_comb begin
      if (role) begin
         edge_ev = tick;
         edge_in = miso_s[1];
      end else begin
         edge_ev = pen && ss_low && sck_s[1] != sck_old_q;
         edge_in = mosi_s[1];
      end
   end

   // sample edges are even indices for phase zero, odd for phase one
   logic samp_e, in_q;
   assign samp_e  = eidx_q[0] == clock_phase_bit;
   assign done_ev = edge_ev && eidx_q == `SPM_LAST_EDGE;
   always_comb begin
      if (clock_phase_bit && done_ev)
         sh_nxt = {sh_q[6:0], edge_in};
      else
         sh_nxt = {sh_q[6:0], in_q};
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         eidx_q <= 4'h0;
      else if (!role && !ss_low)
         eidx_q <= 4'h0;
      else if (role && m_state != SPM_RUN)
         eidx_q <= 4'h0;
      else if (edge_ev)
         eidx_q <= eidx_q + 4'h1;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         in_q <= 1'b0;
      else if (edge_ev && samp_e)
         in_q <= edge_in;
   end

   // slave with phase one counts as busy from its first edge on
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         sl_run_q <= 1'b0;
      else if (role || !ss_low || done_ev)
         sl_run_q <= 1'b0;
      else if (edge_ev)
         sl_run_q <= 1'b1;
   end

   assign busy = role ? m_state == SPM_RUN
                      : pen && ss_low && (!clock_phase_bit || sl_run_q);
   assign blocked = role && tc_q && !seen_q;

   // -----------------------------------------------------------------
   // master sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         m_state <= SPM_IDLE;
      else begin
         case (m_state)
            SPM_IDLE:
               if (wr_data && role && pen && !busy && !blocked)
                  m_state <= SPM_RUN;
            SPM_RUN:
               if (done_ev || !role)
                  m_state <= SPM_IDLE;
            default: m_state <= SPM_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // shift register and receive buffer
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         sh_q <= `SPM_DATA_RST;
      else if (wr_data && !busy && !blocked)
         sh_q <= wb_dat_i[7:0];
      else if (edge_ev && (done_ev || (!samp_e && eidx_q != 4'h0)))
         sh_q <= sh_nxt;
   end

   // a byte finishing while the flag is still set is dropped
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         rx_q <= `SPM_DATA_RST;
      else if (done_ev && !tc_q)
         rx_q <= sh_nxt;
   end

   // -----------------------------------------------------------------
   // status flags
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         seen_q <= 1'b0;
      else if (rd_stat && (tc_q || write_collision_flag_q || mode_fault_flag_q))
         seen_q <= 1'b1;
      else if (dacc || wr_ctrl)
         seen_q <= 1'b0;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         tc_q <= 1'b0;
      else if (done_ev)
         tc_q <= 1'b1;
      else if (dacc && seen_q && tc_q)
         tc_q <= 1'b0;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         write_collision_flag_q <= 1'b0;
      else if (wr_data && busy)
         write_collision_flag_q <= 1'b1;
      else if (wr_data && seen_q && write_collision_flag_q && !tc_q)
         write_collision_flag_q <= 1'b1;
      else if (dacc && seen_q && write_collision_flag_q)
         write_collision_flag_q <= 1'b0;
   end

   // a master's select must stay high; a low one is a mode fault
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         mode_fault_flag_q <= 1'b0;
      else if (pen && role && ss_low)
         mode_fault_flag_q <= 1'b1;
      else if (wr_ctrl && seen_q)
         mode_fault_flag_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // pin drive and interrupt
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sck_oe  <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         irq_o   <= 1'b0;
      end else begin
         sck_oe  <= pen && role;
         mosi_oe <= pen && role;
         miso_oe <= pen && !role && ss_low;
         irq_o   <= ctrl_q[`SPM_CTRL_IRQEN] && (tc_q || mode_fault_flag_q);
      end
   end
   assign sck_o  = sck_q;
   assign mosi_o = sh_q[7];
   assign miso_o = sh_q[7];

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_mstart;
      wr_data && role && pen && !busy && !blocked;
   endsequence
   sequence s_mrun;
      m_state == SPM_RUN [*8];
   endsequence

   irq_follow_a: assert property (
      ctrl_q[`SPM_CTRL_IRQEN] && (tc_q || mode_fault_flag_q) |=> irq_o)
      else $error("irq not raised");
   pins_off_a: assert property (
      !pen |=> !sck_oe && !mosi_oe && !miso_oe)
      else $error("pins driven while disabled");
   role_dir_a: assert property (
      pen && role |=> sck_oe && mosi_oe && !miso_oe)
      else $error("master pin direction wrong");
   master_run_a: assert property (
      s_mstart |=> s_mrun)
      else $error("master transfer did not run");
   slave_nostart_a: assert property (
      wr_data && !role && m_state == SPM_IDLE |=> m_state == SPM_IDLE)
      else $error("slave write started transfer");
   tc_load_a: assert property (
      done_ev && !tc_q |=> tc_q && rx_q == $past(sh_nxt))
      else $error("complete flag or buffer not set");
   tc_clear_a: assert property (
      $fell(tc_q) |-> $past(seen_q) && $past(dacc))
      else $error("complete flag cleared without sequence");
   blocked_wr_a: assert property (
      wr_data && blocked && !edge_ev |=> sh_q == $past(sh_q))
      else $error("blocked write reached shift register");
   write_collision_flag_set_a: assert property (
      wr_data && busy && !done_ev |=> write_collision_flag_q && m_state == $past(m_state))
      else $error("collision not flagged");
   overrun_keep_a: assert property (
      done_ev && tc_q |=> rx_q == $past(rx_q))
      else $error("overrun byte overwrote buffer");
   bus_ack_a: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not single cycle");
endmodule

// *** tb/spm_far_slave.sv ***
// far-side slave model, clock phase zero and idle-low clock
`timescale 1ns/1ps
module spm_far_slave (
   input  wire logic               sck,
   input  wire logic               mosi,
   input  wire logic               sel_n,
   input  wire spm_pkg::spm_byte_t reply,
   output      logic               miso,
   output      spm_pkg::spm_byte_t got,
   output      int                 count
);
   import spm_pkg::*;
   spm_byte_t tx;
   spm_byte_t rx;
   int        bits;
   initial begin
      miso = 1'b0;
      got = 8'h00;
      count = 0;
      bits = 0;
   end
   // first bit must stand before the first clock edge
   always @(negedge sel_n) begin
      tx = reply;
      bits = 0;
      miso = reply[7];
   end
   always @(posedge sck) begin
      if (!sel_n) begin
         rx = {rx[6:0], mosi};
         bits++;
         if (bits == 8) begin
            got = rx;
            count++;
         end
      end
   end
   always @(negedge sck) begin
      if (!sel_n && bits < 8) begin
         tx = {tx[6:0], 1'b0};
         miso = tx[7];
      end
   end
   // released line: show the inverse so a stale sample is caught
   always @(posedge sel_n) begin
      miso = ~miso;
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench of the serial port in master and slave role
`timescale 1ns/1ps
`include "spm_defines.svh"
module tb_top;
   import spm_pkg::*;
   logic       sys_clk, nrst, wb_cyc, wb_stb, wb_we, sel_n, irq, wb_ack, ss_n, tb_sck, tb_mosi;
   logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, far_miso;
   logic [3:0] wb_adr, wb_sel;
   spm_word_t  wb_wdat, wb_rdat;
   spm_byte_t  reply, got, rd;
   int         count, fails, checks_done;
   wire logic  sck_w = sck_oe ? sck_o : tb_sck;
   wire logic  mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire logic  miso_w = miso_oe ? miso_o : far_miso;

   spm_port i_dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .irq_o(irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n));
   spm_far_slave i_far (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n), .reply(reply), .miso(far_miso),
      .got(got), .count(count));

   // ----------------------------------------
   // bus cycles and comparisons
   // ----------------------------------------
   task automatic check8(input spm_byte_t g, input spm_byte_t e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic check1(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // waits for ack as long as it takes; only the watchdog ends a hang
   task automatic wb_acc(input logic we, input logic [3:0] a, input spm_byte_t d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_wdat <= {24'h000000, d};
      do begin
         @(posedge sys_clk);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [3:0] a, input spm_byte_t d);
      wb_acc(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [3:0] a, input spm_byte_t e);
      wb_acc(1'b0, a, 8'h00);
      check8(rd, e);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // bench as far master: phase zero, idle-low clock, six cycles per half period
   task automatic sl_byte(input spm_byte_t b, output spm_byte_t s);
      s = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         tb_mosi <= b[i];
         repeat (6) @(posedge sys_clk);
         tb_sck <= 1'b1;
         s = {s[6:0], miso_w};
         repeat (6) @(posedge sys_clk);
         tb_sck <= 1'b0;
      end
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic t_reset();
      rd_chk(`SPM_OFS_CTRL, 8'h00);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      rd_chk(`SPM_OFS_DATA, 8'h00);
      rd_chk(4'hC, 8'h00);
      check1(sck_oe, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_exchange();
      reply = 8'h3C;
      sel_n <= 1'b0;
      wr(`SPM_OFS_CTRL, 8'hD2);
      check1(sck_oe, 1'b1);
      check1(miso_oe, 1'b0);
      wr(`SPM_OFS_DATA, 8'hA5);
      wait_irq();
      check1(irq, 1'b1);
      check8(got, 8'hA5);
      // no status read yet, so this write must vanish
      wr(`SPM_OFS_DATA, 8'h77);
      repeat (40) @(posedge sys_clk);
      check8(8'(count), 8'h01);
      rd_chk(`SPM_OFS_STAT, 8'h80);
      rd_chk(`SPM_OFS_DATA, 8'h3C);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      check1(irq, 1'b0);
      sel_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      $display("test exchange done");
   endtask
   task automatic t_collision();
      reply = 8'hC3;
      sel_n <= 1'b0;
      wr(`SPM_OFS_DATA, 8'h5A);
      wr(`SPM_OFS_DATA, 8'h11);
      rd_chk(`SPM_OFS_STAT, 8'h40);
      check1(irq, 1'b0);
      // armed clearing sequence spoilt by a write before completion
      wr(`SPM_OFS_DATA, 8'h22);
      rd_chk(`SPM_OFS_STAT, 8'h40);
      rd_chk(`SPM_OFS_DATA, 8'h3C);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      wr(`SPM_OFS_DATA, 8'h33);
      wait_irq();
      check8(got, 8'h5A);
      rd_chk(`SPM_OFS_STAT, 8'hC0);
      rd_chk(`SPM_OFS_DATA, 8'hC3);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      sel_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      $display("test collision done");
   endtask
   task automatic t_slave();
      wr(`SPM_OFS_CTRL, 8'hD0);
      ss_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check1(irq, 1'b1);
      rd_chk(`SPM_OFS_STAT, 8'h10);
      ss_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr(`SPM_OFS_CTRL, 8'h40);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      check1(sck_oe, 1'b0);
      check1(mosi_oe, 1'b0);
      wr(`SPM_OFS_DATA, 8'h99);
      repeat (40) @(posedge sys_clk);
      check8(8'(count), 8'h02);
      check1(miso_oe, 1'b0);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      $display("test slave done");
   endtask
   task automatic t_slave_xfer();
      spm_byte_t s;
      ss_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check1(miso_oe, 1'b1);
      wr(`SPM_OFS_DATA, 8'h22);
      sl_byte(8'h6B, s);
      check8(s, 8'h99);
      ss_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ss_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      sl_byte(8'hE4, s);
      check8(s, 8'h6B);
      ss_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd_chk(`SPM_OFS_STAT, 8'hC0);
      rd_chk(`SPM_OFS_DATA, 8'h6B);
      rd_chk(`SPM_OFS_STAT, 8'h00);
      $display("test slave transfer done");
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // two master and two slave transfers of under 150 cycles each, plus register traffic
   initial begin
      #25000;
      fails++;
      print_verdict();
   end
   initial begin
      fails = 0;
      checks_done = 0;
      nrst = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_sel = 4'hF;
      wb_wdat = 32'h00000000;
      sel_n = 1'b1;
      ss_n = 1'b1;
      tb_sck = 1'b0;
      tb_mosi = 1'b0;
      reply = 8'h00;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_exchange();
      t_collision();
      t_slave();
      t_slave_xfer();
      print_verdict();
   end
endmodule
